// ### hdl/lrw_burst.sv
// lrw_burst: read/write burst engine of a low-power ddr sdram, apb config.
// assumes ck, command, dq, dm and dqs pins are asynchronous to pclk and
// that ck is much slower than pclk (edges are found by oversampling).
// Operation
// - read carries bank, column and auto precharge; row closes after burst if chosen
// - first read element appears read latency (2 or 3) ck cycles after read
// - device drives strobe; elements aligned to successive strobe edges, first rising
// - with no further read, data and strobe outputs release after the burst
// - x32 lanes: each byte of dq timed by its own strobe
// - x16 lanes: lower strobe times low byte, upper strobe high byte
// - new read burst data follows the last wanted element without a gap
// - burst 4 reads concatenate; burst 8 or 16 reads interrupt
// - burst stop ends a read after read latency, issued after wanted pairs
// - burst stop leaves the row open, no precharge
// - read auto precharge starts burst/2 cycles after read, once row-active met
// - write data taken from first rising strobe edge, then every strobe edge
// - masked write elements leave stored data unchanged
// - after a write burst further input data is ignored
// - a write may follow any earlier write on any edge, data flows on
// - back-to-back writes may switch bank
// - auto precharge bit chosen per read or write, does not persist
`timescale 1ns/10ps
module lrw_burst import lrw_pkg::*; #(
    parameter int NUM_BYTES = LRW_NUM_BYTES_DEF,
    parameter logic [LRW_CNT_W-1:0] ROW_ACTIVE_CK = LRW_RAS_CK_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [LRW_APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ck,
    input wire lrw_cmd_type cmd,
    input wire logic [NUM_BYTES*LRW_BYTE_W-1:0] dq_in,
    input wire logic [NUM_BYTES-1:0] dm_in,
    input wire logic [NUM_BYTES-1:0] dqs_in,
    output logic [NUM_BYTES*LRW_BYTE_W-1:0] dq_out,
    output logic [NUM_BYTES-1:0] dq_oe,
    output logic [NUM_BYTES-1:0] dqs_out,
    output logic [NUM_BYTES-1:0] dqs_oe
);

    localparam int DW = NUM_BYTES * LRW_BYTE_W;
    localparam int MAW = LRW_BA_W + LRW_COL_W;
    localparam int NB = NUM_BYTES;

    typedef struct packed {
        logic [2:0] ck_s;
        lrw_cmd_type cmd_s1;
        lrw_cmd_type cmd_s2;
        logic [NB-1:0] dqs_s1;
        logic [NB-1:0] dqs_s2;
        logic [NB-1:0] dqs_s3;
        logic [DW-1:0] dq_s1;
        logic [DW-1:0] dq_s2;
        logic [NB-1:0] dm_s1;
        logic [NB-1:0] dm_s2;
        logic cfg_cl3;
        logic [1:0] cfg_bl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [LRW_NUM_BANKS-1:0] open;
        logic [LRW_NUM_BANKS-1:0] ap_pend;
        logic [LRW_NUM_BANKS-1:0][LRW_CNT_W-1:0] ras_cnt;
        logic [LRW_NUM_BANKS-1:0][LRW_CNT_W-1:0] ap_cnt;
        lrw_rq_type [2:0] rq;
        logic [LRW_BA_W-1:0] rd_ba;
        logic [LRW_COL_W-1:0] rd_col;
        logic [LRW_BURST_W-1:0] rd_idx;
        logic [LRW_BURST_W-1:0] rd_left;
        logic [MAW-1:0] mem_raddr;
        lrw_drv_type [1:0] drv;
        logic [DW-1:0] dq_out;
        logic [NB-1:0] dq_oe;
        logic [NB-1:0] dqs_out;
        logic [NB-1:0] dqs_oe;
        logic wr_pend;
        logic wr_arm;
        logic wr_pend_ap;
        logic [LRW_BA_W-1:0] wr_pend_ba;
        logic [LRW_COL_W-1:0] wr_pend_col;
        logic wr_ap;
        logic [LRW_BA_W-1:0] wr_ba;
        logic [LRW_COL_W-1:0] wr_col;
        logic [LRW_BURST_W-1:0] wr_idx;
        logic [LRW_BURST_W-1:0] wr_left;
        logic [DW-1:0] cap_dq;
        logic [NB-1:0] cap_dm;
        logic commit;
        logic [MAW-1:0] commit_addr;
        logic mem_we;
        logic [MAW-1:0] mem_waddr;
        logic [DW-1:0] mem_wdata;
        logic [NB-1:0] mem_be;
    } lrw_state_type;

    lrw_state_type st_reg;
    lrw_state_type st_next;
    logic [DW-1:0] mem_rdata;
    logic ck_rise;
    logic ck_fall;
    logic cmd_valid;
    lrw_op_type op;
    lrw_rq_type head;
    logic [LRW_BURST_W-1:0] bl;
    logic dqs_r0;
    logic dqs_f0;
    logic apb_acc;
    logic [LRW_NUM_BANKS-1:0] ap_due;

    // edges seen on the second and third flops, never the first
    assign ck_rise = st_reg.ck_s[1] & ~st_reg.ck_s[2];
    assign ck_fall = ~st_reg.ck_s[1] & st_reg.ck_s[2];
    assign cmd_valid = ck_rise & ~st_reg.cmd_s2.cs_n;
    assign op = lrw_op_type'({st_reg.cmd_s2.ras_n, st_reg.cmd_s2.cas_n, st_reg.cmd_s2.we_n});
    assign head = st_reg.cfg_cl3 ? st_reg.rq[2] : st_reg.rq[1];
    assign bl = lrw_burst_elems(st_reg.cfg_bl);
    assign dqs_r0 = st_reg.dqs_s2[0] & ~st_reg.dqs_s3[0];
    assign dqs_f0 = ~st_reg.dqs_s2[0] & st_reg.dqs_s3[0];
    assign apb_acc = psel & penable & ~st_reg.pready;

    genvar gb;
    generate
        for (gb = 0; gb < LRW_NUM_BANKS; gb++) begin : g_bank
            assign ap_due[gb] = st_reg.ap_pend[gb] && (st_reg.ap_cnt[gb] <= LRW_CNT_ONE)
                && (st_reg.ras_cnt[gb] >= ROW_ACTIVE_CK);
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        st_next.ck_s = {st_reg.ck_s[1:0], ck};
        st_next.cmd_s1 = cmd;
        st_next.cmd_s2 = st_reg.cmd_s1;
        st_next.dqs_s1 = dqs_in;
        st_next.dqs_s2 = st_reg.dqs_s1;
        st_next.dqs_s3 = st_reg.dqs_s2;
        st_next.dq_s1 = dq_in;
        st_next.dq_s2 = st_reg.dq_s1;
        st_next.dm_s1 = dm_in;
        st_next.dm_s2 = st_reg.dm_s1;
        st_next.mem_we = 1'b0;
        st_next.commit = 1'b0;
        st_next.drv[1] = st_reg.drv[0];
        st_next.drv[0] = DRV_NONE;

        // pad stage; every lane strobe moves with its byte
        case (st_reg.drv[1])
            DRV_HIGH: begin
                st_next.dq_out = mem_rdata;
                st_next.dq_oe = '1;
                st_next.dqs_out = '1;
                st_next.dqs_oe = '1;
            end
            DRV_LOW: begin
                st_next.dq_out = mem_rdata;
                st_next.dqs_out = '0;
            end
            DRV_OFF: begin
                st_next.dq_oe = '0;
                st_next.dqs_oe = '0;
                st_next.dqs_out = '0;
            end
            default: begin
            end
        endcase

        if (ck_rise) begin
            st_next.rq[2] = st_reg.rq[1];
            st_next.rq[1] = st_reg.rq[0];
            st_next.rq[0] = '0;
            for (int b = 0; b < LRW_NUM_BANKS; b++) begin
                if (st_reg.ras_cnt[b] != '1) begin
                    st_next.ras_cnt[b] = st_reg.ras_cnt[b] + 1'b1;
                end
                if (ap_due[b]) begin
                    st_next.open[b] = 1'b0;
                    st_next.ap_pend[b] = 1'b0;
                end else if (st_reg.ap_pend[b] && st_reg.ap_cnt[b] > LRW_CNT_ONE) begin
                    st_next.ap_cnt[b] = st_reg.ap_cnt[b] - 1'b1;
                end
            end
            if (cmd_valid) begin
                case (op)
                    OP_ACT: begin
                        st_next.open[st_reg.cmd_s2.ba] = 1'b1;
                        st_next.ras_cnt[st_reg.cmd_s2.ba] = '0;
                        st_next.ap_pend[st_reg.cmd_s2.ba] = 1'b0;
                    end
                    OP_READ: begin
                        st_next.rq[0] = '{kind: RQ_READ, ba: st_reg.cmd_s2.ba,
                            col: st_reg.cmd_s2.addr[LRW_COL_W-1:0]};
                        if (st_reg.cmd_s2.addr[LRW_AP_BIT]) begin
                            st_next.ap_pend[st_reg.cmd_s2.ba] = 1'b1;
                            st_next.ap_cnt[st_reg.cmd_s2.ba] = LRW_CNT_W'(bl >> 1);
                        end
                    end
                    OP_STOP: begin
                        // rides the same latency pipe, bank state untouched
                        st_next.rq[0] = '{kind: RQ_STOP, ba: '0, col: '0};
                    end
                    OP_WRITE: begin
                        st_next.wr_pend = 1'b1;
                        st_next.wr_arm = 1'b0;
                        st_next.wr_pend_ap = st_reg.cmd_s2.addr[LRW_AP_BIT];
                        st_next.wr_pend_ba = st_reg.cmd_s2.ba;
                        st_next.wr_pend_col = st_reg.cmd_s2.addr[LRW_COL_W-1:0];
                    end
                    OP_PRE: begin
                        if (st_reg.cmd_s2.addr[LRW_AP_BIT]) begin
                            st_next.open = '0;
                            st_next.ap_pend = '0;
                        end else begin
                            st_next.open[st_reg.cmd_s2.ba] = 1'b0;
                            st_next.ap_pend[st_reg.cmd_s2.ba] = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (head.kind == RQ_READ) begin
                // a new read simply restarts the sequence: no gap, old one cut
                st_next.rd_ba = head.ba;
                st_next.rd_col = head.col;
                st_next.rd_idx = 5'h01;
                st_next.rd_left = bl - 1'b1;
                st_next.mem_raddr = {head.ba, lrw_burst_col(head.col, '0, st_reg.cfg_bl)};
                st_next.drv[0] = DRV_HIGH;
            end else if (head.kind == RQ_STOP || st_reg.rd_left == '0) begin
                st_next.rd_left = '0;
                st_next.drv[0] = DRV_OFF;
            end else begin
                st_next.mem_raddr = {st_reg.rd_ba,
                    lrw_burst_col(st_reg.rd_col, st_reg.rd_idx, st_reg.cfg_bl)};
                st_next.rd_idx = st_reg.rd_idx + 1'b1;
                st_next.rd_left = st_reg.rd_left - 1'b1;
                st_next.drv[0] = DRV_HIGH;
            end
        end

        if (ck_fall) begin
            // strobe rises cannot belong to the new write before this point
            if (st_reg.wr_pend) begin
                st_next.wr_arm = 1'b1;
            end
            if (st_reg.rd_left != '0) begin
                st_next.mem_raddr = {st_reg.rd_ba,
                    lrw_burst_col(st_reg.rd_col, st_reg.rd_idx, st_reg.cfg_bl)};
                st_next.rd_idx = st_reg.rd_idx + 1'b1;
                st_next.rd_left = st_reg.rd_left - 1'b1;
                st_next.drv[0] = DRV_LOW;
            end
        end

        // each lane latched on its own strobe; lane skew must stay under a pclk
        for (int i = 0; i < NB; i++) begin
            if (st_reg.dqs_s2[i] != st_reg.dqs_s3[i]) begin
                st_next.cap_dq[i*LRW_BYTE_W +: LRW_BYTE_W] =
                    st_reg.dq_s2[i*LRW_BYTE_W +: LRW_BYTE_W];
                st_next.cap_dm[i] = st_reg.dm_s2[i];
            end
        end
        if (dqs_r0 && st_reg.wr_pend && st_reg.wr_arm) begin
            st_next.wr_pend = cmd_valid && op == OP_WRITE;
            st_next.wr_arm = 1'b0;
            st_next.wr_ap = st_reg.wr_pend_ap;
            st_next.wr_ba = st_reg.wr_pend_ba;
            st_next.wr_col = st_reg.wr_pend_col;
            st_next.wr_idx = 5'h01;
            st_next.wr_left = bl - 1'b1;
            st_next.commit = 1'b1;
            st_next.commit_addr = {st_reg.wr_pend_ba,
                lrw_burst_col(st_reg.wr_pend_col, '0, st_reg.cfg_bl)};
        end else if ((dqs_r0 || dqs_f0) && st_reg.wr_left != '0) begin
            st_next.wr_idx = st_reg.wr_idx + 1'b1;
            st_next.wr_left = st_reg.wr_left - 1'b1;
            st_next.commit = 1'b1;
            st_next.commit_addr = {st_reg.wr_ba,
                lrw_burst_col(st_reg.wr_col, st_reg.wr_idx, st_reg.cfg_bl)};
            if (st_reg.wr_left == 5'h01 && st_reg.wr_ap) begin
                st_next.ap_pend[st_reg.wr_ba] = 1'b1;
                st_next.ap_cnt[st_reg.wr_ba] = LRW_CNT_ONE;
            end
        end
        // any other strobe edge carries data nobody asked for: dropped
        if (st_reg.commit) begin
            st_next.mem_we = 1'b1;
            st_next.mem_waddr = st_reg.commit_addr;
            st_next.mem_wdata = st_reg.cap_dq;
            st_next.mem_be = ~st_reg.cap_dm;
        end

        // one wait state: pready rises on the second access cycle
        st_next.pready = apb_acc;
        st_next.pslverr = 1'b0;
        st_next.prdata = '0;
        if (apb_acc) begin
            if (paddr == LRW_CFG_OFS) begin
                st_next.prdata[LRW_CFG_CL_LSB +: 2] = st_reg.cfg_cl3 ? LRW_CL3 : LRW_CL2;
                st_next.prdata[LRW_CFG_BL_LSB +: 2] = st_reg.cfg_bl;
            end else if (paddr == LRW_STAT_OFS) begin
                st_next.prdata[LRW_STAT_OPEN_LSB +: LRW_NUM_BANKS] = st_reg.open;
                st_next.prdata[LRW_STAT_RD_BIT] = |st_reg.dq_oe;
                st_next.prdata[LRW_STAT_WR_BIT] = st_reg.wr_pend | (st_reg.wr_left != '0);
            end else begin
                st_next.pslverr = 1'b1;
            end
        end
        if (psel && penable && st_reg.pready && pwrite && paddr == LRW_CFG_OFS) begin
            // unsupported latency codes are ignored, old value kept
            if (pwdata[LRW_CFG_CL_LSB +: 2] == LRW_CL2 || pwdata[LRW_CFG_CL_LSB +: 2] == LRW_CL3) begin
                st_next.cfg_cl3 = (pwdata[LRW_CFG_CL_LSB +: 2] == LRW_CL3);
            end
            st_next.cfg_bl = pwdata[LRW_CFG_BL_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.cfg_cl3 <= 1'b1;
            st_reg.cfg_bl <= LRW_BL_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    lrw_mem #(.DATA_W(DW), .ADDR_W(MAW), .NUM_BYTES(NB)) u_mem (
        .clk(pclk),
        .we(st_reg.mem_we),
        .be(st_reg.mem_be),
        .waddr(st_reg.mem_waddr),
        .wdata(st_reg.mem_wdata),
        .raddr(st_reg.mem_raddr),
        .rdata(mem_rdata)
    );

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign dq_out = st_reg.dq_out;
    assign dq_oe = st_reg.dq_oe;
    assign dqs_out = st_reg.dqs_out;
    assign dqs_oe = st_reg.dqs_oe;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    read_latency_a: assert property (ck_rise && head.kind == RQ_READ |-> ##3
        (dq_oe == '1 && dqs_oe == '1 && dqs_out == '1)) else $error("read data not driven");
    strobe_fall_a: assert property (ck_fall && st_reg.rd_left != '0 |-> ##3
        (dqs_out == '0 && dq_oe == '1)) else $error("strobe not low with odd element");
    read_release_a: assert property (ck_rise && head.kind != RQ_READ &&
        st_reg.rd_left == '0 |-> ##3 (dq_oe == '0 && dqs_oe == '0)) else $error("no release");
    read_restart_a: assert property (ck_rise && head.kind == RQ_READ |=>
        (st_reg.rd_left == $past(bl) - 1'b1 && st_reg.rd_col == $past(head.col)))
        else $error("new read did not restart burst");
    stop_cut_a: assert property (ck_rise && head.kind == RQ_STOP |=>
        st_reg.rd_left == '0) else $error("burst stop ignored");
    stop_row_open_a: assert property (cmd_valid && op == OP_STOP &&
        st_reg.ap_pend == '0 |=> $stable(st_reg.open)) else $error("burst stop closed a row");
    ap_close_a: assert property (ck_rise && ap_due != '0 && !(cmd_valid && op == OP_ACT)
        |=> (st_reg.open & $past(ap_due)) == '0) else $error("auto precharge missed");
    write_start_a: assert property (dqs_r0 && st_reg.wr_pend && st_reg.wr_arm |=>
        (st_reg.wr_ba == $past(st_reg.wr_pend_ba) && st_reg.commit &&
        st_reg.wr_left == $past(bl) - 1'b1)) else $error("write burst not loaded");
    mask_block_a: assert property (st_reg.commit |=>
        (st_reg.mem_we && st_reg.mem_be == ~$past(st_reg.cap_dm))) else $error("mask lost");
    write_ignore_a: assert property ((dqs_r0 || dqs_f0) && st_reg.wr_left == '0 &&
        !(st_reg.wr_pend && st_reg.wr_arm) |=> ##1 !st_reg.mem_we) else $error("stray write");

endmodule // lrw_burst

// ### hdl/lrw_pkg.sv
// lrw_pkg: constants, pin carriers and burst helpers for the burst engine.
// assumes a single pclk domain; pin-side values arrive unsynchronised.
package lrw_pkg;

    localparam int LRW_ADDR_W = 14;
    localparam int LRW_BA_W = 2;
    localparam int LRW_COL_W = 10;
    localparam int LRW_NUM_BANKS = 4;
    localparam int LRW_AP_BIT = 10;
    localparam int LRW_BYTE_W = 8;
    localparam int LRW_NUM_BYTES_DEF = 2;
    localparam int LRW_CNT_W = 4;
    localparam int LRW_BURST_W = 5;

    localparam logic [LRW_CNT_W-1:0] LRW_RAS_CK_DEF = 4'h4;
    localparam logic [LRW_CNT_W-1:0] LRW_CNT_ONE = 4'h1;

    // apb map
    localparam int LRW_APB_AW = 12;
    localparam logic [LRW_APB_AW-1:0] LRW_CFG_OFS = 12'h000;
    localparam logic [LRW_APB_AW-1:0] LRW_STAT_OFS = 12'h004;
    localparam int LRW_CFG_CL_LSB = 0;
    localparam int LRW_CFG_BL_LSB = 4;
    localparam int LRW_STAT_OPEN_LSB = 0;
    localparam int LRW_STAT_RD_BIT = 4;
    localparam int LRW_STAT_WR_BIT = 5;
    localparam logic [1:0] LRW_CL2 = 2'h2;
    localparam logic [1:0] LRW_CL3 = 2'h3;
    localparam logic [1:0] LRW_BL_RST = 2'h1;

    // {ras_n, cas_n, we_n}
    typedef enum logic [2:0] {
        OP_MRS = 3'b000,
        OP_REF = 3'b001,
        OP_PRE = 3'b010,
        OP_ACT = 3'b011,
        OP_WRITE = 3'b100,
        OP_READ = 3'b101,
        OP_STOP = 3'b110,
        OP_NOP = 3'b111
    } lrw_op_type;

    typedef enum logic [1:0] {
        RQ_NONE = 2'b00,
        RQ_READ = 2'b01,
        RQ_STOP = 2'b10
    } lrw_rq_kind_type;

    typedef enum logic [1:0] {
        DRV_NONE = 2'b00,
        DRV_HIGH = 2'b01,
        DRV_LOW = 2'b10,
        DRV_OFF = 2'b11
    } lrw_drv_type;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [LRW_BA_W-1:0] ba;
        logic [LRW_ADDR_W-1:0] addr;
    } lrw_cmd_type;

    typedef struct packed {
        lrw_rq_kind_type kind;
        logic [LRW_BA_W-1:0] ba;
        logic [LRW_COL_W-1:0] col;
    } lrw_rq_type;

    // burst_length_setting code 0..3 -> 2, 4, 8, 16 elements
    function automatic logic [LRW_BURST_W-1:0] lrw_burst_elems(input logic [1:0] code);
        return 5'h02 << code;
    endfunction

    // sequential order, wraps inside the burst-aligned block
    function automatic logic [LRW_COL_W-1:0] lrw_burst_col(
        input logic [LRW_COL_W-1:0] start,
        input logic [LRW_BURST_W-1:0] idx,
        input logic [1:0] code
    );
        logic [LRW_COL_W-1:0] m;
        m = LRW_COL_W'(lrw_burst_elems(code)) - 1'b1;
        return (start & ~m) | ((start + LRW_COL_W'(idx)) & m);
    endfunction

endpackage

// ### hdl/lrw_mem.sv
// lrw_mem: byte-lane masked array, one write and one registered read port.
// assumes the caller holds raddr one cycle before it wants rdata.
`timescale 1ns/10ps
module lrw_mem import lrw_pkg::*; #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 12,
    parameter int NUM_BYTES = 2
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [NUM_BYTES-1:0] be,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [ADDR_W-1:0] raddr,
    output logic [DATA_W-1:0] rdata
);

    logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];
    logic [DATA_W-1:0] rdata_reg;

    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_BYTES; i++) begin
            if (we && be[i]) begin
                mem[waddr][i*LRW_BYTE_W +: LRW_BYTE_W] <= wdata[i*LRW_BYTE_W +: LRW_BYTE_W];
            end
        end
        rdata_reg <= mem[raddr];
    end

    assign rdata = rdata_reg;

endmodule // lrw_mem

// ### verif/lrw_ctl_model.sv
// lrw_ctl_model: controller stand-in for link clock, commands and write data.
// assumes the bench calls its tasks in order; ck runs free at 40 pclk.
`timescale 1ns/10ps
module lrw_ctl_model import lrw_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    output logic ck,
    output lrw_cmd_type cmd,
    output logic [15:0] dq_in,
    output logic [1:0] dm_in,
    output logic [1:0] dqs_in
);
    logic [5:0] cnt_reg;
    assign ck = cnt_reg < 6'h14;
    initial begin
        cmd = {1'b1, OP_NOP, 16'h0000};
        dq_in = 16'h0000;
        dm_in = 2'h0;
        dqs_in = 2'h0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_reg <= 6'h14;
        else cnt_reg <= (cnt_reg == 6'h27) ? 6'h00 : cnt_reg + 6'h01;
    end
    task automatic at(input int c);
        @(posedge pclk);
        while (cnt_reg != c) @(posedge pclk);
    endtask
    // held 10 pclk either side of the ck rise, ample for the 2-flop sync
    task automatic cmd_go(input lrw_op_type op, input logic [1:0] ba, input logic [13:0] a);
        at(30);
        cmd <= {1'b0, op, ba, a};
        at(10);
        cmd <= {1'b1, OP_NOP, 16'h0000};
    endtask
    // centre-aligned: data moves a quarter ck before each strobe edge
    task automatic burst(input logic [15:0] b, input logic [1:0] m1);
        for (int e = 0; e < 4; e++) begin
            at(e % 2 ? 10 : 30);
            dq_in <= b + 16'h0101 * 16'(e);
            dm_in <= (e == 1) ? m1 : 2'h0;
            at(e % 2 ? 20 : 0);
            dqs_in <= (e % 2) ? 2'h0 : 2'h3;
        end
    endtask
    task automatic release_dq();
        at(30);
        dq_in <= ~dq_in;
        at(0);
        dqs_in <= 2'h3;
        at(20);
        dqs_in <= 2'h0;
    endtask
endmodule // lrw_ctl_model

// ### verif/tb.sv
// tb: apb config and status access plus write and read bursts on the pins.
// assumes lrw_ctl_model drives the controller side of the link.
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("mismatch %0t got %h exp %h", $time, (a), (e)); end end
module tb import lrw_pkg::*; ;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, ck;
    lrw_cmd_type cmd;
    logic [15:0] dq_in, dq_out;
    logic [1:0] dm_in, dqs_in, dq_oe, dqs_out, dqs_oe;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    lrw_burst i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .ck, .cmd, .dq_in, .dm_in, .dqs_in, .dq_out, .dq_oe, .dqs_out,
        .dqs_oe);
    lrw_ctl_model i_ctl (.pclk, .presetn, .ck, .cmd, .dq_in, .dm_in, .dqs_in);
    initial begin
        forever #2 pclk = ~pclk;
    end
    // ceiling well above the roughly 1500 cycles the sequence needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // for reads d is the expected prdata
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic se);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        `CHK(pslverr, se)
        if (!w) `CHK(prdata, d)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // element 1 keeps the first burst's low byte, masked in the second
    function automatic logic [15:0] expd(input int e);
        return (e == 1) ? 16'hC1B1 : 16'hC0D0 + 16'h0101 * 16'(e);
    endfunction
    task automatic rd(input int cl, input logic [13:0] a, input int n);
        i_ctl.cmd_go(OP_READ, 2'h1, a);
        if (n < 4) i_ctl.cmd_go(OP_STOP, 2'h0, 14'h0000);
        if (n > 4) begin
            i_ctl.at(39);
            i_ctl.cmd_go(OP_READ, 2'h1, a);
        end
        repeat (cl - (n < 4) - 2 * (n > 4)) i_ctl.at(39);
        for (int e = 0; e < n; e++) begin
            i_ctl.at(e % 2 ? 35 : 15);
            `CHK(dq_out, expd(e % 4))
            `CHK({dqs_out, dqs_oe, dq_oe}, {((e % 2) ? 2'h0 : 2'h3), 4'hF})
        end
        i_ctl.at(15);
        `CHK({dq_oe, dqs_oe}, 4'h0)
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, LRW_CFG_OFS, 32'h0000_0013, 1'b0);
        apb(1'b0, 12'h008, 32'h0000_0000, 1'b1);
        i_ctl.cmd_go(OP_ACT, 2'h1, 14'h0000);
        apb(1'b0, LRW_STAT_OFS, 32'h0000_0002, 1'b0);
        i_ctl.at(10);
        fork
            begin
                i_ctl.cmd_go(OP_WRITE, 2'h1, 14'h0004);
                i_ctl.at(0);
                i_ctl.cmd_go(OP_WRITE, 2'h1, 14'h0004);
            end
            begin
                i_ctl.at(0);
                i_ctl.burst(16'hA0B0, 2'h0);
                i_ctl.burst(16'hC0D0, 2'h1);
            end
        join
        i_ctl.release_dq();
        rd(3, 14'h0004, 4);
        rd(3, 14'h0004, 8);
        apb(1'b1, LRW_CFG_OFS, 32'h0000_0012, 1'b0);
        rd(2, 14'h0004, 2);
        apb(1'b0, LRW_STAT_OFS, 32'h0000_0002, 1'b0);
        rd(2, 14'h0404, 4);
        apb(1'b0, LRW_STAT_OFS, 32'h0000_0000, 1'b0);
        i_ctl.cmd_go(OP_ACT, 2'h2, 14'h0000);
        apb(1'b0, LRW_STAT_OFS, 32'h0000_0004, 1'b0);
        i_ctl.cmd_go(OP_READ, 2'h2, 14'h0000);
        i_ctl.at(39);
        i_ctl.cmd_go(OP_PRE, 2'h2, 14'h0000);
        repeat (3) i_ctl.at(15);
        apb(1'b0, LRW_STAT_OFS, 32'h0000_0000, 1'b0);
        tally_and_finish();
    end
endmodule // tb
